// ### common/cst_defines.svh
// Function
// R01 - Magnitude bits 7-4, type bits 3-0
// R02 - Reserved codes rejected, field keeps value
// R03 - Types 0000-0011 make magnitude a voltage; code does so for 0001-0011 only
// R04 - Voltage ladder decode, 1111 reserved
// R05 - Resistor types decode fourteen resistor steps; code decodes fifteen, magnitudes 0000-1110
// R06 - Divider types decode minimum divider resistance
// R07 - Types 0000-0011 remove or apply voltage
// R08 - Resistor, divider and bridge type decode
// R09 - Type 1110 keeps/removes reset pull-downs
// R10 - Type 1111 behaves like 1110
// R11 - Untargeted pin keeps pull-down under select 000
// R12 - Pull-down current bits 5-4, magnitude 0000
// R13 - Threshold field decode, 1111 reserved
// R14 - Threshold ignored for select 000/111
// R15 - Current/threshold updated only for BC1.2 profiles
// R16 - Divider ratio bits 2-0, 111 reserved
// R17 - Divider ratio updated only for legacy
// R18 - Select 000 ready, 111 present, no wait
// R19 - Unimplemented bits read zero, writes ignored
// R20 - All fields reset to zero
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH
`define CST_IDX_STIM     8'h41
`define CST_IDX_RESP     8'h42
`define CST_IDX_THRESH   8'h43
`define CST_IDX_DIVIDER  8'h44
`define CST_IDX_SHIFT    2
`define CST_MAG_MSB      7
`define CST_MAG_LSB      4
`define CST_SEL_MSB      3
`define CST_SEL_LSB      0
`define CST_PD_MSB       5
`define CST_PD_LSB       4
`define CST_TH_MSB       3
`define CST_TH_LSB       0
`define CST_RATIO_MSB    2
`define CST_RATIO_LSB    0
`define CST_STIM_MSB     2
`define CST_STIM_LSB     0
`define CST_RST4         4'h0
`define CST_RST3         3'h0
`define CST_RST2         2'h0
`define CST_MAG_RSVD     4'hF
`define CST_TH_RSVD      4'hF
`define CST_RATIO_RSVD   3'h7
`define CST_STIM_VREADY  3'h0
`define CST_STIM_VPRES   3'h7
`endif

// ### common/cst_pkg.sv
package cst_pkg;
   typedef enum logic [3:0] {
      RT_REMOVE   = 4'b0000,
      RT_V_POS    = 4'b0001,
      RT_V_NEG    = 4'b0010,
      RT_V_BOTH   = 4'b0011,
      RT_R_POS    = 4'b0100,
      RT_RSVD5    = 4'b0101,
      RT_D_POS    = 4'b0110,
      RT_R_NEG    = 4'b0111,
      RT_RSVD8    = 4'b1000,
      RT_D_NEG    = 4'b1001,
      RT_BRIDGE   = 4'b1010,
      RT_RSVD11   = 4'b1011,
      RT_D_BOTH   = 4'b1100,
      RT_R_BOTH   = 4'b1101,
      RT_PD_CTRL  = 4'b1110,
      RT_PD_CTRL2 = 4'b1111
   } cst_resp_t;

   typedef enum logic [2:0] {
      PA_LEAVE   = 3'b000,
      PA_REMOVE  = 3'b001,
      PA_VOLT    = 3'b010,
      PA_RES     = 3'b011,
      PA_DIV     = 3'b100,
      PA_BRIDGE  = 3'b101,
      PA_KEEP_PD = 3'b110,
      PA_DROP_PD = 3'b111
   } cst_pin_act_t;

   typedef struct packed {
      cst_pin_act_t posAction;
      cst_pin_act_t negAction;
      logic [11:0]  voltageMv;
      logic [10:0]  resistor100R;
      logic [7:0]   dividerMinK;
      logic         pulldownActive;
      logic [7:0]   pulldownUa;
      logic         thresholdValid;
      logic [11:0]  thresholdMv;
      logic [6:0]   ratioPercent;
      logic         vbusReady;
      logic         vbusPresent;
   } cst_resp_out_t;
endpackage : cst_pkg

// ### src/cst_stim1_config.sv
`timescale 1ns/1ps
`include "cst_defines.svh"
module cst_stim1_config
   import cst_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          legacyProfile,
   output cst_resp_out_t      stim1Response
);
   logic [3:0]  stim1ResponseMagnitude;
   logic [3:0]  stim1ResponseSelect;
   logic [2:0]  stim1StimulusSelect;
   logic [1:0]  stim1PulldownCurrent;
   logic [3:0]  stim1DetectThreshold;
   logic [2:0]  stim1DividerRatio;
   logic [1:0]  appliedPulldown;
   logic [3:0]  appliedThreshold;
   logic [2:0]  appliedRatio;
   logic        accessPhase;
   logic        writeFire;
   logic        hitStim;
   logic        hitResp;
   logic        hitThresh;
   logic        hitDivider;
   logic        mapped;
   logic [31:0] next_prdata;
   logic [3:0]  wrMag;
   logic [3:0]  wrSel;
   logic [3:0]  wrTh;
   logic [2:0]  wrRatio;
   cst_resp_out_t next_response;

   function automatic logic [11:0] byteAddr(input logic [7:0] idx);
      byteAddr = {2'h0, idx, 2'h0};
   endfunction : byteAddr

   // Ladder for response voltage; detection threshold has its own decode
   function automatic logic [11:0] ladderMv(input logic [3:0] code);
      unique case (code)
         4'h0:    ladderMv = 12'h000;
         4'h5:    ladderMv = 12'h1F4;
         4'h6:    ladderMv = 12'h258;
         4'h7:    ladderMv = 12'h2BC;
         4'h8:    ladderMv = 12'h320;
         4'h9:    ladderMv = 12'h384;
         4'hA:    ladderMv = 12'h578;
         4'hB:    ladderMv = 12'h640;
         4'hC:    ladderMv = 12'h708;
         4'hD:    ladderMv = 12'h7D0;
         4'hE:    ladderMv = 12'h898;
         4'hF:    ladderMv = 12'h000;
         default: ladderMv = 12'h190;
      endcase
   endfunction : ladderMv

   function automatic logic [10:0] resistorCode(input logic [3:0] code);
      unique case (code)
         4'h0:    resistorCode = 11'h012;
         4'h1:    resistorCode = 11'h064;
         4'h2:    resistorCode = 11'h096;
         4'h3:    resistorCode = 11'h0C8;
         4'h4:    resistorCode = 11'h0FA;
         4'h5:    resistorCode = 11'h12C;
         4'h6:    resistorCode = 11'h190;
         4'h7:    resistorCode = 11'h1AE;
         4'h8:    resistorCode = 11'h1F4;
         4'h9:    resistorCode = 11'h258;
         4'hA:    resistorCode = 11'h2EE;
         4'hB:    resistorCode = 11'h320;
         4'hC:    resistorCode = 11'h3E8;
         4'hD:    resistorCode = 11'h4B0;
         4'hE:    resistorCode = 11'h5DC;
         default: resistorCode = 11'h000;
      endcase
   endfunction : resistorCode

   function automatic logic [7:0] dividerCode(input logic [3:0] code);
      unique case (code)
         4'h0, 4'h8: dividerCode = 8'h5D;
         4'h1, 4'h9: dividerCode = 8'h64;
         4'h2, 4'hA: dividerCode = 8'h7D;
         4'h3, 4'hB: dividerCode = 8'h96;
         4'hF:       dividerCode = 8'h00;
         default:    dividerCode = 8'hC8;
      endcase
   endfunction : dividerCode

   function automatic logic [6:0] ratioCode(input logic [2:0] code);
      unique case (code)
         3'h0:    ratioCode = 7'h19;
         3'h1:    ratioCode = 7'h21;
         3'h2:    ratioCode = 7'h28;
         3'h3:    ratioCode = 7'h32;
         3'h4:    ratioCode = 7'h36;
         3'h5:    ratioCode = 7'h3C;
         3'h6:    ratioCode = 7'h42;
         default: ratioCode = 7'h00;
      endcase
   endfunction : ratioCode

   function automatic logic [7:0] pulldownUaCode(input logic [1:0] code);
      unique case (code)
         2'h0: pulldownUaCode = 8'h0A;
         2'h1: pulldownUaCode = 8'h32;
         2'h2: pulldownUaCode = 8'h64;
         2'h3: pulldownUaCode = 8'h96;
      endcase
   endfunction : pulldownUaCode

   function automatic logic respReserved(input logic [3:0] code);
      respReserved = (code == RT_RSVD5) || (code == RT_RSVD8) || (code == RT_RSVD11);
   endfunction : respReserved

   // Threshold decode departs from the response ladder at 0000 and 0011
   function automatic logic [11:0] thresholdCode(input logic [3:0] code);
      unique case (code)
         4'h0: thresholdCode = 12'h190;
         4'h1: thresholdCode = 12'h190;
         4'h2: thresholdCode = 12'h190;
         4'h3: thresholdCode = 12'h12C;
         4'h4: thresholdCode = 12'h190;
         4'h5: thresholdCode = 12'h1F4;
         4'h6: thresholdCode = 12'h258;
         4'h7: thresholdCode = 12'h2BC;
         4'h8: thresholdCode = 12'h320;
         4'h9: thresholdCode = 12'h384;
         4'hA: thresholdCode = 12'h578;
         4'hB: thresholdCode = 12'h640;
         4'hC: thresholdCode = 12'h708;
         4'hD: thresholdCode = 12'h7D0;
         4'hE: thresholdCode = 12'h898;
         4'hF: thresholdCode = 12'h000;
      endcase
   endfunction : thresholdCode

   function automatic logic isVoltageType(input logic [3:0] code);
      unique case (code)
         RT_V_POS, RT_V_NEG, RT_V_BOTH: isVoltageType = 1'b1;
         default:                       isVoltageType = 1'b0;
      endcase
   endfunction : isVoltageType

   // Pull-down control types still carry a resistor magnitude
   function automatic logic isResistorType(input logic [3:0] code);
      unique case (code)
         RT_R_POS, RT_R_NEG, RT_R_BOTH, RT_PD_CTRL, RT_PD_CTRL2: isResistorType = 1'b1;
         default:                                              isResistorType = 1'b0;
      endcase
   endfunction : isResistorType

   function automatic logic isDividerType(input logic [3:0] code);
      unique case (code)
         RT_D_POS, RT_D_NEG, RT_D_BOTH: isDividerType = 1'b1;
         default:                       isDividerType = 1'b0;
      endcase
   endfunction : isDividerType

   // APB decode; answer comes one cycle into the access phase
   assign accessPhase = psel && penable;
   assign writeFire   = accessPhase && pready && pwrite;
   assign hitStim     = paddr == byteAddr(`CST_IDX_STIM);
   assign hitResp     = paddr == byteAddr(`CST_IDX_RESP);
   assign hitThresh   = paddr == byteAddr(`CST_IDX_THRESH);
   assign hitDivider  = paddr == byteAddr(`CST_IDX_DIVIDER);
   assign mapped      = hitStim || hitResp || hitThresh || hitDivider;
   assign wrMag       = pwdata[`CST_MAG_MSB:`CST_MAG_LSB];
   assign wrSel       = pwdata[`CST_SEL_MSB:`CST_SEL_LSB];
   assign wrTh        = pwdata[`CST_TH_MSB:`CST_TH_LSB];
   assign wrRatio     = pwdata[`CST_RATIO_MSB:`CST_RATIO_LSB];

   always_comb begin
      next_prdata = 32'h0000_0000; // R19
      if (hitStim) begin
         next_prdata[`CST_STIM_MSB:`CST_STIM_LSB] = stim1StimulusSelect;
      end else if (hitResp) begin
         next_prdata[`CST_MAG_MSB:`CST_MAG_LSB] = stim1ResponseMagnitude; // R01
         next_prdata[`CST_SEL_MSB:`CST_SEL_LSB] = stim1ResponseSelect;
      end else if (hitThresh) begin
         next_prdata[`CST_PD_MSB:`CST_PD_LSB] = stim1PulldownCurrent;
         next_prdata[`CST_TH_MSB:`CST_TH_LSB] = stim1DetectThreshold;
      end else if (hitDivider) begin
         next_prdata[`CST_RATIO_MSB:`CST_RATIO_LSB] = stim1DividerRatio;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= accessPhase && !pready;
         pslverr <= accessPhase && !pready && !mapped;
         // Read data is captured in the first access cycle and stands until the next read
         if (accessPhase && !pready && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stim1StimulusSelect <= `CST_RST3; // R20
      end else if (writeFire && hitStim) begin
         stim1StimulusSelect <= pwdata[`CST_STIM_MSB:`CST_STIM_LSB];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stim1ResponseMagnitude <= `CST_RST4; // R20
         stim1ResponseSelect    <= `CST_RST4;
      end else if (writeFire && hitResp) begin
         // A reserved code leaves only its own field alone
         if (wrMag != `CST_MAG_RSVD) begin // R02
            stim1ResponseMagnitude <= wrMag; // R01
         end
         if (!respReserved(wrSel)) begin // R02
            stim1ResponseSelect <= wrSel; // R01
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stim1PulldownCurrent <= `CST_RST2; // R20
         stim1DetectThreshold <= `CST_RST4;
      end else if (writeFire && hitThresh) begin
         stim1PulldownCurrent <= pwdata[`CST_PD_MSB:`CST_PD_LSB]; // R12
         if (wrTh != `CST_TH_RSVD) begin // R13
            stim1DetectThreshold <= wrTh;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stim1DividerRatio <= `CST_RST3; // R20
      end else if (writeFire && hitDivider && wrRatio != `CST_RATIO_RSVD) begin // R16
         stim1DividerRatio <= wrRatio;
      end
   end

   // Settings held for the profile that uses them; the other kind freezes them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         appliedPulldown  <= `CST_RST2;
         appliedThreshold <= `CST_RST4;
         appliedRatio     <= `CST_RST3;
      end else if (legacyProfile) begin
         appliedRatio <= stim1DividerRatio; // R17
      end else begin
         appliedPulldown  <= stim1PulldownCurrent; // R15
         appliedThreshold <= stim1DetectThreshold; // R15
      end
   end

   always_comb begin
      next_response                = '0;
      next_response.posAction      = PA_LEAVE;
      next_response.negAction      = PA_LEAVE;
      next_response.vbusReady      = stim1StimulusSelect == `CST_STIM_VREADY; // R18
      next_response.vbusPresent    = stim1StimulusSelect == `CST_STIM_VPRES; // R18
      next_response.pulldownUa     = pulldownUaCode(appliedPulldown); // R12
      next_response.thresholdMv    = thresholdCode(appliedThreshold); // R13
      next_response.thresholdValid = !next_response.vbusReady
                                     && !next_response.vbusPresent; // R14
      next_response.ratioPercent   = ratioCode(appliedRatio); // R16
      unique case (stim1ResponseSelect)
         RT_REMOVE: begin
            next_response.posAction = PA_REMOVE; // R07
            next_response.negAction = PA_REMOVE;
         end
         RT_V_POS: begin
            next_response.posAction = PA_VOLT; // R07
         end
         RT_V_NEG: begin
            next_response.negAction = PA_VOLT; // R07
         end
         RT_V_BOTH: begin
            next_response.posAction = PA_VOLT; // R07
            next_response.negAction = PA_VOLT;
         end
         RT_R_POS: begin
            next_response.posAction = PA_RES; // R08
         end
         RT_R_NEG: begin
            next_response.negAction = PA_RES; // R08
         end
         RT_R_BOTH: begin
            next_response.posAction = PA_RES; // R08
            next_response.negAction = PA_RES;
         end
         RT_D_POS: begin
            next_response.posAction = PA_DIV; // R08
         end
         RT_D_NEG: begin
            next_response.negAction = PA_DIV; // R08
         end
         RT_D_BOTH: begin
            next_response.posAction = PA_DIV; // R08
            next_response.negAction = PA_DIV;
         end
         RT_BRIDGE: begin
            next_response.posAction = PA_BRIDGE; // R08
            next_response.negAction = PA_BRIDGE;
         end
         RT_PD_CTRL, RT_PD_CTRL2: begin
            if (next_response.vbusReady) begin // R09 R10
               next_response.posAction = PA_KEEP_PD;
               next_response.negAction = PA_KEEP_PD;
            end else if (next_response.vbusPresent) begin
               next_response.posAction = PA_DROP_PD;
               next_response.negAction = PA_DROP_PD;
            end
         end
         default: begin
         end
      endcase
      // Under select 000, single-pin responses keep the other pin's reset pull-down
      if (next_response.vbusReady) begin
         if (next_response.posAction == PA_LEAVE) begin
            next_response.posAction = PA_KEEP_PD; // R11
         end
         if (next_response.negAction == PA_LEAVE) begin
            next_response.negAction = PA_KEEP_PD; // R11
         end
      end
      if (isVoltageType(stim1ResponseSelect)) begin
         next_response.voltageMv      = ladderMv(stim1ResponseMagnitude); // R03 R04
         next_response.pulldownActive = stim1ResponseMagnitude == `CST_RST4; // R12
      end
      if (isResistorType(stim1ResponseSelect)) begin
         next_response.resistor100R = resistorCode(stim1ResponseMagnitude); // R05
      end
      // Ratio is only meaningful while a divider is connected
      if (isDividerType(stim1ResponseSelect)) begin
         next_response.dividerMinK = dividerCode(stim1ResponseMagnitude); // R06
      end else begin
         next_response.ratioPercent = 7'h00;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stim1Response <= '0;
      end else begin
         stim1Response <= next_response;
      end
   end
endmodule : cst_stim1_config

// ### dv/cst_stim1_config_asserts.sv
`timescale 1ns/1ps
module cst_stim1_config_asserts
   import cst_pkg::*;
(
   input wire logic          clk,
   input wire logic          reset_n,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          legacyProfile,
   input wire cst_resp_out_t stim1Response
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_decode: assert property (pready |-> pslverr == !(paddr inside {12'h104, 12'h108,
      12'h10C, 12'h110})) else $error("pslverr wrong for address");
   a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
      else $error("prdata changed outside a read");
   a_thr_valid: assert property (reset_n && $past(reset_n) |-> stim1Response.thresholdValid ==
      !(stim1Response.vbusReady || stim1Response.vbusPresent)) else $error("thresholdValid wrong");
   a_drop_both: assert property (stim1Response.posAction == PA_DROP_PD |->
      stim1Response.negAction == PA_DROP_PD && stim1Response.vbusPresent)
      else $error("pull-down drop not on both pins");
   a_keep_ready: assert property (stim1Response.posAction == PA_KEEP_PD ||
      stim1Response.negAction == PA_KEEP_PD |-> stim1Response.vbusReady)
      else $error("pull-down kept without ready select");
   a_bridge_pair: assert property (stim1Response.posAction == PA_BRIDGE |->
      stim1Response.negAction == PA_BRIDGE) else $error("bridge on one pin only");
   a_pd_zero: assert property (stim1Response.pulldownActive |-> stim1Response.voltageMv == 0)
      else $error("pull-down with nonzero voltage");
endmodule : cst_stim1_config_asserts

// ### dv/cst_portable_dev.sv
`timescale 1ns/1ps
module cst_portable_dev
   import cst_pkg::*;
(
   input  wire cst_resp_out_t stim1Response,
   output logic               posLoaded,
   output logic               negLoaded
);
   // A pin sees a load unless it is released or its reset pull-down dropped
   assign posLoaded = !(stim1Response.posAction inside {PA_REMOVE, PA_DROP_PD});
   assign negLoaded = !(stim1Response.negAction inside {PA_REMOVE, PA_DROP_PD});
endmodule : cst_portable_dev

// ### dv/tb_cst_stim1_config.sv
`timescale 1ns/1ps
module tb_cst_stim1_config
   import cst_pkg::*;
;
   logic          clk, reset_n, psel, penable, pwrite, legacy, pready, pslverr, err;
   logic          posLoaded, negLoaded;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   cst_resp_out_t rsp;
   int            error_cnt, num_checks;
   logic [2:0]    sSel, sRat, hRat;
   logic [3:0]    sMag, sTyp, sTh, hTh;
   logic [1:0]    sPd, hPd;
   logic [10:0]   resTab [0:14] = '{11'h012, 11'h064, 11'h096, 11'h0C8, 11'h0FA, 11'h12C,
      11'h190, 11'h1AE, 11'h1F4, 11'h258, 11'h2EE, 11'h320, 11'h3E8, 11'h4B0, 11'h5DC};
   logic [7:0]    divTab [0:3] = '{8'h5D, 8'h64, 8'h7D, 8'h96};
   logic [7:0]    pdTab [0:3] = '{8'h0A, 8'h32, 8'h64, 8'h96};
   logic [6:0]    ratTab [0:6] = '{7'h19, 7'h21, 7'h28, 7'h32, 7'h36, 7'h3C, 7'h42};

   cst_stim1_config u_cst_stim1_config (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .legacyProfile(legacy), .stim1Response(rsp));
   cst_portable_dev u_cst_portable_dev (.stim1Response(rsp), .posLoaded(posLoaded),
      .negLoaded(negLoaded));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   function automatic logic [11:0] volt(input logic [3:0] c);
      if (c == 4'h0) return 12'h000;
      if (c < 4'h5) return 12'h190;
      if (c < 4'hA) return 12'(c) * 12'h064;
      return 12'h578 + (12'(c) - 12'h00A) * 12'h0C8;
   endfunction : volt

   function automatic cst_pin_act_t act(input logic pos);
      cst_pin_act_t u;
      u = (sSel == 3'h0) ? PA_KEEP_PD : PA_LEAVE;
      case (sTyp)
         4'h0: return PA_REMOVE;
         4'h1: return pos ? PA_VOLT : u;
         4'h2: return pos ? u : PA_VOLT;
         4'h3: return PA_VOLT;
         4'h4: return pos ? PA_RES : u;
         4'h6: return pos ? PA_DIV : u;
         4'h7: return pos ? u : PA_RES;
         4'h9: return pos ? u : PA_DIV;
         4'hA: return PA_BRIDGE;
         4'hC: return PA_DIV;
         4'hD: return PA_RES;
         default: return (sSel == 3'h0) ? PA_KEEP_PD : (sSel == 3'h7) ? PA_DROP_PD : PA_LEAVE;
      endcase
   endfunction : act

   function automatic logic [31:0] regv(input int idx);
      case (idx)
         0: return {29'h0, sSel};
         1: return {24'h0, sMag, sTyp};
         2: return {26'h0, sPd, sTh};
         default: return {29'h0, sRat};
      endcase
   endfunction : regv

   task automatic verify();
      logic dv;
      dv = sTyp inside {4'h6, 4'h9, 4'hC};
      if (!legacy) begin
         hPd = sPd;
         hTh = sTh;
      end else hRat = sRat;
      chk("posAction", rsp.posAction, act(1'b1));
      chk("negAction", rsp.negAction, act(1'b0));
      chk("posLoaded", posLoaded, !(act(1'b1) inside {PA_REMOVE, PA_DROP_PD}));
      chk("negLoaded", negLoaded, !(act(1'b0) inside {PA_REMOVE, PA_DROP_PD}));
      if (sTyp inside {4'h1, 4'h2, 4'h3}) begin
         chk("voltageMv", rsp.voltageMv, volt(sMag));
         chk("pulldownActive", rsp.pulldownActive, sMag == 4'h0);
      end
      if (sTyp inside {4'h4, 4'h7, 4'hD, 4'hE, 4'hF})
         chk("resistor", rsp.resistor100R, resTab[sMag]);
      if (dv) chk("dividerMinK", rsp.dividerMinK, sMag[2] ? 8'hC8 : divTab[sMag[1:0]]);
      chk("pulldownUa", rsp.pulldownUa, pdTab[hPd]);
      chk("thresholdMv", rsp.thresholdMv, (hTh == 4'h3) ? 12'h12C :
         (hTh == 4'h0) ? 12'h190 : volt(hTh));
      chk("thresholdValid", rsp.thresholdValid, !(sSel inside {3'h0, 3'h7}));
      chk("vbusReady", rsp.vbusReady, sSel == 3'h0);
      chk("vbusPresent", rsp.vbusPresent, sSel == 3'h7);
      chk("ratioPercent", rsp.ratioPercent, dv ? ratTab[hRat] : 7'h00);
   endtask : verify

   task automatic wreg(input int idx, input logic [31:0] d);
      apb(1'b1, 12'h104 + 12'(idx * 4), d);
      chk("pslverr", err, 32'h0000_0000);
      case (idx)
         0: sSel = d[2:0];
         1: begin
            if (d[7:4] != 4'hF) sMag = d[7:4];
            if (!(d[3:0] inside {4'h5, 4'h8, 4'hB})) sTyp = d[3:0];
         end
         2: begin
            sPd = d[5:4];
            if (d[3:0] != 4'hF) sTh = d[3:0];
         end
         default: if (d[2:0] != 3'h7) sRat = d[2:0];
      endcase
      repeat (4) @(posedge clk);
      verify();
      apb(1'b0, 12'h104 + 12'(idx * 4), 32'h0000_0000);
      chk("readback", rd, regv(idx));
   endtask : wreg

   initial begin
      {reset_n, psel, penable, pwrite, legacy, paddr, pwdata} = '0;
      {error_cnt, num_checks} = '0;
      {sSel, sRat, hRat, sMag, sTyp, sTh, hTh, sPd, hPd} = '0;
      void'($urandom(6));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      verify();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'h104 + 12'(i * 4), 32'h0000_0000);
         chk("reset value", rd, 32'h0000_0000);
      end
      $display("test reset done");
      for (int s = 0; s < 3; s++) begin
         for (int t = 0; t < 16; t++) begin
            legacy <= 1'($urandom);
            wreg(0, (s == 0) ? 32'h0000_0000 : (s == 1) ? 32'h0000_0007 : $urandom);
            wreg(1, 32'(t * 17));
            wreg(2, 32'(t * 17));
            wreg(3, 32'(t));
         end
      end
      $display("test codes done");
      for (int n = 0; n < 40; n++) begin
         legacy <= 1'($urandom);
         wreg(int'($urandom % 4), $urandom);
      end
      $display("test random done");
      apb(1'b1, 12'h100, 32'h0000_00FF);
      chk("pslverr", err, 32'h0000_0001);
      apb(1'b0, 12'h114, 32'h0000_0000);
      chk("pslverr", err, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'h104 + 12'(i * 4), 32'h0000_0000);
         chk("unchanged", rd, regv(i));
      end
      $display("test unmapped done");
      test_done();
   end

   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      test_done();
   end
endmodule : tb_cst_stim1_config

bind cst_stim1_config cst_stim1_config_asserts u_cst_stim1_config_asserts (.clk(clk),
   .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .legacyProfile(legacyProfile), .stim1Response(stim1Response));
